// ---- core/cirl_pkg.sv ----
/*
 * constants, types and vector layout of the cpu interrupt request logic.
 * assumes one cpu clock domain and 16-bit cpu words.
 */
package cirl_pkg;
	localparam int FLAG_W = 16;
	localparam int WORD_W = 16;
	localparam int GMASK_BIT = 9;
	localparam int EXT_N = 2;
	localparam int VEC_IDX_W = 5;
	localparam logic [15:0] FLAG_RST = 16'h0000;
	localparam logic [15:0] MASK_RST = 16'h0000;
	localparam logic GMASK_RST = 1'b1;
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [15:0] VEC_RST = 16'h0000;
	// maskable flag k uses vector index k + MASK_VEC_BASE
	localparam logic [4:0] MASK_VEC_BASE = 5'h01;
	localparam logic [4:0] NMI_VEC_IDX = 5'h12;
	typedef enum logic [1:0] {ST_IDLE, ST_VEC, ST_SVC} cirl_state_e;
endpackage

// ---- core/cirl_top.sv ----
/*
 * cpu maskable and nonmaskable interrupt request logic: pending flags,
 * enable mask, global mask bit, vector selection, acknowledge and pc save.
 * assumes the cpu core drives the word write strobes and the sequencing
 * inputs on CLK; the pins EXT_IRQ and NMI_PIN are asynchronous.
 */
// Notes on behaviour
// - 16-bit pending flags readable by software
// - writing one clears a flag, zero keeps
// - mask bit one enables its interrupt
// - global mask at status word bit 9
// - ack strobe while vector is fetched
// - branch to the interrupt's fixed vector address
// - requests from pins, peripherals and instructions
// - masked requests never enter a service routine
// - nonmaskable request ignores both masks
// - registered request stays pending until acknowledged or cleared by writing one
// - only program counter saved and restored
module cirl_top import cirl_pkg::*; (
	input wire logic CLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic [EXT_N-1:0] EXT_IRQ,
	input wire logic NMI_PIN,
	input wire logic [FLAG_W-1:0] PERIPH_REQ,
	input wire logic SW_INT_REQ,
	input wire logic [VEC_IDX_W-1:0] SW_INT_IDX,
	input wire logic INSTR_BOUNDARY,
	input wire logic [WORD_W-1:0] CPU_PC,
	input wire logic VEC_FETCH_DONE,
	input wire logic INT_RETURN,
	input wire logic FLAG_WR,
	input wire logic [FLAG_W-1:0] FLAG_WR_DATA,
	input wire logic MASK_WR,
	input wire logic [FLAG_W-1:0] MASK_WR_DATA,
	input wire logic STATUS_WR,
	input wire logic [WORD_W-1:0] STATUS_WR_DATA,
	output logic [FLAG_W-1:0] FLAG_Q,
	output logic [FLAG_W-1:0] MASK_Q,
	output logic GLOBAL_MASK,
	output logic ACK_STROBE,
	output logic [WORD_W-1:0] VEC_ADDR,
	output logic [WORD_W-1:0] SAVED_PC,
	output logic PC_RESTORE,
	output logic INT_ACTIVE
);
	function automatic logic [3:0] lowest_set(input logic [FLAG_W-1:0] v);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = FLAG_W - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = i[3:0];
			end
		end
		return idx;
	endfunction

	function automatic logic [WORD_W-1:0] vec_of(input logic [VEC_IDX_W-1:0] idx);
		// two words per vector slot: room for a branch and its target
		return {{(WORD_W-VEC_IDX_W-1){1'b0}}, idx, 1'b0};
	endfunction

	cirl_state_e state_r, state_nxt;
	logic [EXT_N-1:0] ext_s1_r, ext_s2_r, ext_s3_r;
	logic nmi_s1_r, nmi_s2_r, nmi_s3_r;
	logic [FLAG_W-1:0] flag_r, flag_nxt, mask_r, mask_nxt;
	logic gmask_r, gmask_nxt;
	logic nmi_pend_r, nmi_pend_nxt;
	logic sw_pend_r, sw_pend_nxt;
	logic [VEC_IDX_W-1:0] sw_idx_r, sw_idx_nxt;
	logic [WORD_W-1:0] vec_r, vec_nxt, pc_r, pc_nxt;
	logic restore_r, restore_nxt;

	// logic reads the second stage onward; the third only remembers the last level
	wire [EXT_N-1:0] ext_rise = ext_s2_r & ~ext_s3_r;
	wire nmi_rise = nmi_s2_r & ~nmi_s3_r;
	wire [FLAG_W-1:0] hw_set = PERIPH_REQ | {{(FLAG_W-EXT_N){1'b0}}, ext_rise};
	wire [FLAG_W-1:0] enabled = flag_r & mask_r & {FLAG_W{~gmask_r}};
	wire any_mask = |enabled;
	wire [3:0] mask_sel = lowest_set(enabled);
	wire take = (state_r == ST_IDLE) && INSTR_BOUNDARY
		&& (nmi_pend_r || sw_pend_r || any_mask);
	wire take_mask = take && !nmi_pend_r && !sw_pend_r;
	wire [VEC_IDX_W-1:0] sel_idx = nmi_pend_r ? NMI_VEC_IDX :
		sw_pend_r ? sw_idx_r : ({1'b0, mask_sel} + MASK_VEC_BASE);
	wire [FLAG_W-1:0] ack_clr = take_mask ? (FLAG_W'(1) << mask_sel) : '0;
	wire [FLAG_W-1:0] sw_clr = FLAG_WR ? FLAG_WR_DATA : '0;

	// a new request wins over either clear in the same cycle
	assign flag_nxt = (flag_r & ~sw_clr & ~ack_clr) | hw_set;
	assign mask_nxt = MASK_WR ? MASK_WR_DATA : mask_r;
	// entry blocks nesting; software reopens through the status word
	assign gmask_nxt = take ? 1'b1 : (STATUS_WR ? STATUS_WR_DATA[GMASK_BIT] : gmask_r);
	assign nmi_pend_nxt = nmi_rise | (nmi_pend_r & ~(take & nmi_pend_r));
	assign sw_pend_nxt = (SW_INT_REQ & ~sw_pend_r)
		| (sw_pend_r & ~(take & ~nmi_pend_r));
	assign sw_idx_nxt = (SW_INT_REQ && !sw_pend_r) ? SW_INT_IDX : sw_idx_r;
	assign vec_nxt = take ? vec_of(sel_idx) : vec_r;
	assign pc_nxt = take ? CPU_PC : pc_r;
	assign restore_nxt = (state_r == ST_SVC) && INT_RETURN;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (take) begin
					state_nxt = ST_VEC;
				end
			end
			ST_VEC: begin
				if (VEC_FETCH_DONE) begin
					state_nxt = ST_SVC;
				end
			end
			ST_SVC: begin
				if (INT_RETURN) begin
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ext_s1_r <= '0;
			ext_s2_r <= '0;
			ext_s3_r <= '0;
			nmi_s1_r <= 1'b0;
			nmi_s2_r <= 1'b0;
			nmi_s3_r <= 1'b0;
		end else if (CE) begin
			ext_s1_r <= EXT_IRQ;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
			nmi_s1_r <= NMI_PIN;
			nmi_s2_r <= nmi_s1_r;
			nmi_s3_r <= nmi_s2_r;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_r <= ST_IDLE;
			flag_r <= FLAG_RST;
			mask_r <= MASK_RST;
			gmask_r <= GMASK_RST;
			nmi_pend_r <= 1'b0;
			sw_pend_r <= 1'b0;
			sw_idx_r <= '0;
			vec_r <= VEC_RST;
			pc_r <= PC_RST;
			restore_r <= 1'b0;
		end else if (CE) begin
			state_r <= state_nxt;
			flag_r <= flag_nxt;
			mask_r <= mask_nxt;
			gmask_r <= gmask_nxt;
			nmi_pend_r <= nmi_pend_nxt;
			sw_pend_r <= sw_pend_nxt;
			sw_idx_r <= sw_idx_nxt;
			vec_r <= vec_nxt;
			pc_r <= pc_nxt;
			restore_r <= restore_nxt;
		end
	end

	assign FLAG_Q = flag_r;
	assign MASK_Q = mask_r;
	assign GLOBAL_MASK = gmask_r;
	assign ACK_STROBE = (state_r == ST_VEC);
	assign VEC_ADDR = vec_r;
	assign SAVED_PC = pc_r;
	assign PC_RESTORE = restore_r;
	assign INT_ACTIVE = (state_r != ST_IDLE);

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	a_flag_read_out: assert property (CE && |PERIPH_REQ |=>
		(FLAG_Q & $past(PERIPH_REQ)) == $past(PERIPH_REQ))
		else $error("pending word lost a request");
	a_flag_w1c: assert property (CE && FLAG_WR && !take |=>
		((flag_r & $past(FLAG_WR_DATA) & ~$past(hw_set)) == '0)
		&& ((flag_r & ~$past(FLAG_WR_DATA)) == ($past(flag_r | hw_set) & ~$past(FLAG_WR_DATA))))
		else $error("write one to clear wrong");
	a_mask_gate: assert property (take_mask |-> mask_r[mask_sel] && !gmask_r)
		else $error("masked flag taken");
	a_gmask_status: assert property (CE && STATUS_WR && !take |=>
		GLOBAL_MASK == $past(STATUS_WR_DATA[GMASK_BIT]))
		else $error("global mask not at bit 9");
	a_ack_window: assert property (CE && take |=> ACK_STROBE && INT_ACTIVE)
		else $error("no ack after entry");
	a_vec_addr: assert property (CE && take |=> VEC_ADDR == vec_of($past(sel_idx)))
		else $error("wrong vector address");
	a_no_masked: assert property (gmask_r && !nmi_pend_r && !sw_pend_r |-> !take)
		else $error("entry while globally masked");
	a_nmi_first: assert property (CE && take && nmi_pend_r && !nmi_rise |=>
		VEC_ADDR == vec_of(NMI_VEC_IDX) && !nmi_pend_r)
		else $error("nonmaskable not served first");
	a_pend_hold: assert property (CE && flag_r[0] && !FLAG_WR && !ack_clr[0] |=> flag_r[0])
		else $error("pending flag lost");
	a_pc_save: assert property (CE && take |=> SAVED_PC == $past(CPU_PC))
		else $error("pc not saved");
	a_ack_clear: assert property (CE && take_mask && !hw_set[mask_sel] |=>
		!flag_r[$past(mask_sel)])
		else $error("flag not cleared by ack");
	a_ext_set: assert property (CE && |ext_rise |=>
		(FLAG_Q[EXT_N-1:0] & $past(ext_rise)) == $past(ext_rise))
		else $error("pin request lost");
	// a frozen cycle must keep flags, state and global mask; a request in it is dropped
	a_ce_freeze: assert property (!CE |=>
		$stable(flag_r) && $stable(state_r) && $stable(gmask_r))
		else $error("state moved while clock enable low");

	c_mask_entry: cover property (take_mask ##1 ACK_STROBE [*2] ##1 state_r == ST_SVC);
	c_nmi_entry: cover property (take && nmi_pend_r);
	c_sw_entry: cover property (take && sw_pend_r && !nmi_pend_r);
	c_return: cover property (PC_RESTORE);
endmodule

// ---- tb/cirl_cpu_model.sv ----
/* cpu core stand-in that ends the vector fetch and the service routine.
   assumes SLOW comes from the bench; answers change at falling edges. */
module cirl_cpu_model (
	input wire logic CLK,
	input wire logic ACK_STROBE,
	input wire logic INT_ACTIVE,
	input wire logic SLOW,
	output logic VEC_FETCH_DONE,
	output logic INT_RETURN
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	logic done_r = 1'b0;
	logic ret_r = 1'b0;
	assign VEC_FETCH_DONE = done_r;
	assign INT_RETURN = ret_r;
	// slow mode stretches both the fetch and the routine
	always @(negedge CLK) begin
		cnt <= INT_ACTIVE ? cnt + 1 : 0;
		done_r <= ACK_STROBE && cnt >= (SLOW ? 4 : 0);
		ret_r <= INT_ACTIVE && !ACK_STROBE && cnt >= (SLOW ? 9 : 2);
	end
endmodule

// ---- tb/cpu_interrupt_request_logic_tb.sv ----
/* self-checking bench of the interrupt request logic.
   assumes the cpu stand-in answers acknowledge and return. */
module cpu_interrupt_request_logic_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cirl_pkg::*;
	logic CLK = 0, RST = 1, CE = 1, NMI_PIN = 0, SW_INT_REQ = 0, INSTR_BOUNDARY = 1, SLOW = 0;
	logic FLAG_WR = 0, MASK_WR = 0, STATUS_WR = 0;
	logic [EXT_N-1:0] EXT_IRQ = '0;
	logic [VEC_IDX_W-1:0] SW_INT_IDX = '0;
	logic [15:0] PERIPH_REQ = '0, CPU_PC = '0, FLAG_WR_DATA = '0, MASK_WR_DATA = '0;
	logic [15:0] STATUS_WR_DATA = '0, FLAG_Q, MASK_Q, VEC_ADDR, SAVED_PC, exp_flags = '0, m;
	logic GLOBAL_MASK, ACK_STROBE, PC_RESTORE, INT_ACTIVE, VEC_FETCH_DONE, INT_RETURN;
	logic [31:0] seed = 72;
	int err_total = 0, cmp_count = 0;
	always #2.5 CLK = ~CLK;
	cirl_top i_cirl_top (.CLK, .RST, .CE, .EXT_IRQ, .NMI_PIN, .PERIPH_REQ, .SW_INT_REQ,
		.SW_INT_IDX, .INSTR_BOUNDARY, .CPU_PC, .VEC_FETCH_DONE, .INT_RETURN, .FLAG_WR,
		.FLAG_WR_DATA, .MASK_WR, .MASK_WR_DATA, .STATUS_WR, .STATUS_WR_DATA, .FLAG_Q, .MASK_Q,
		.GLOBAL_MASK, .ACK_STROBE, .VEC_ADDR, .SAVED_PC, .PC_RESTORE, .INT_ACTIVE);
	cirl_cpu_model i_cirl_cpu_model (.CLK, .ACK_STROBE, .INT_ACTIVE, .SLOW, .VEC_FETCH_DONE,
		.INT_RETURN);
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	function automatic logic [15:0] vec_of(input logic [4:0] idx);
		return {10'h000, idx, 1'b0};
	endfunction
	function automatic logic [4:0] low_idx(input logic [15:0] v);
		for (int k = 15; k >= 0; k--) if (v[k]) low_idx = 5'(k) + MASK_VEC_BASE;
	endfunction
	task check(input logic [15:0] seen, input logic [15:0] want);
		cmp_count++;
		if (seen !== want) begin
			err_total++;
			$display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task tick(input int n);
		repeat (n) @(negedge CLK);
	endtask
	task wr(input int sel, input logic [15:0] d);
		FLAG_WR = (sel == 0);
		MASK_WR = (sel == 1);
		STATUS_WR = (sel == 2);
		{FLAG_WR_DATA, MASK_WR_DATA, STATUS_WR_DATA} = {d, d, d};
		tick(1);
		{FLAG_WR, MASK_WR, STATUS_WR} = 3'h0;
	endtask
	task service(input logic [15:0] want_vec);
		int n;
		n = 0;
		while (ACK_STROBE !== 1'b1 && n++ < 20) tick(1);
		check(ACK_STROBE, 1'b1);
		check(VEC_ADDR, want_vec);
		check(SAVED_PC, CPU_PC);
		check(GLOBAL_MASK, 1'b1);
		while (PC_RESTORE !== 1'b1 && n++ < 60) tick(1);
		check(PC_RESTORE, 1'b1);
		check(INT_ACTIVE, 1'b0);
		tick(1);
		$display("service test done vec=%h", want_vec);
	endtask
	task report_and_stop;
		$display("compared %0d mismatched %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#20000;
		err_total++;
		report_and_stop;
	end
	initial begin
		tick(5);
		RST = 0;
		check(FLAG_Q, 16'h0000);
		check(MASK_Q, 16'h0000);
		check(GLOBAL_MASK, 1'b1);
		repeat (4) begin
			PERIPH_REQ = rnd();
			exp_flags |= PERIPH_REQ;
			tick(1);
			PERIPH_REQ = 16'h0000;
			tick(1);
			check(FLAG_Q, exp_flags);
			check(INT_ACTIVE, 1'b0);
			m = rnd();
			wr(0, m);
			exp_flags &= ~m;
			check(FLAG_Q, exp_flags);
		end
		// a request in the clearing cycle must survive
		PERIPH_REQ = 16'h0001;
		wr(0, 16'hffff);
		PERIPH_REQ = 16'h0000;
		exp_flags = 16'h0001;
		check(FLAG_Q, exp_flags);
		tick(1);
		m = rnd() | 16'h8000;
		wr(1, m);
		check(MASK_Q, m);
		PERIPH_REQ = 16'h8000;
		exp_flags |= 16'h8000;
		tick(1);
		PERIPH_REQ = 16'h0000;
		wr(2, 16'h0200);
		tick(2);
		check(GLOBAL_MASK, 1'b1);
		check(INT_ACTIVE, 1'b0);
		check(FLAG_Q, exp_flags);
		$display("flag and mask test done");
		CPU_PC = rnd();
		wr(2, 16'hfdff);
		check(GLOBAL_MASK, 1'b0);
		service(vec_of(low_idx(exp_flags & m)));
		exp_flags[low_idx(exp_flags & m) - MASK_VEC_BASE] = 1'b0;
		check(FLAG_Q, exp_flags);
		wr(1, 16'h0000);
		SLOW = 1;
		CPU_PC = rnd();
		NMI_PIN = 1;
		service(vec_of(NMI_VEC_IDX));
		NMI_PIN = 0;
		SLOW = 0;
		// no entry may start away from an instruction boundary
		INSTR_BOUNDARY = 0;
		SW_INT_IDX = 5'h03;
		CPU_PC = rnd();
		SW_INT_REQ = 1;
		tick(1);
		SW_INT_REQ = 0;
		tick(3);
		check(INT_ACTIVE, 1'b0);
		INSTR_BOUNDARY = 1;
		service(vec_of(5'h03));
		repeat (3) begin
			SW_INT_IDX = 5'(rnd());
			CPU_PC = rnd();
			SW_INT_REQ = 1;
			tick(1);
			SW_INT_REQ = 0;
			service(vec_of(SW_INT_IDX));
		end
		EXT_IRQ = 2'h2;
		tick(4);
		exp_flags[1] = 1'b1;
		check(FLAG_Q, exp_flags);
		EXT_IRQ = 2'h0;
		$display("pin test done");
		CE = 0;
		PERIPH_REQ = 16'h0004;
		tick(2);
		check(FLAG_Q, exp_flags);
		PERIPH_REQ = 16'h0000;
		CE = 1;
		tick(1);
		check(FLAG_Q, exp_flags);
		$display("clock enable test done");
		report_and_stop;
	end
endmodule
